// ---- rtl/mcat_defs.vh ----
// constants for the master clock and converter timing block
`ifndef MCAT_DEFS_VH
`define MCAT_DEFS_VH
// ************************************************************
// register indexes on the plain register port
// ************************************************************
`define MCAT_AW            3
`define MCAT_DW            16
`define MCAT_REG_CLK_CTRL  3'h0
`define MCAT_REG_SYS_CFG   3'h1
`define MCAT_REG_ADC_CTRL  3'h2
`define MCAT_REG_ADC_DIV   3'h3
`define MCAT_REG_ADC_STAT  3'h4
`define MCAT_REG_ADC_RES   3'h5
`define MCAT_REG_CLK_STAT  3'h6
// ************************************************************
// field positions
// ************************************************************
`define MCAT_F_SRC         1:0
`define MCAT_F_IDIV        3:2
`define MCAT_F_ODIV        7:4
`define MCAT_F_MUL         12:8
`define MCAT_F_PRESC       15:14
`define MCAT_F_STIME       13:12
`define MCAT_B_IMPROVED    11
`define MCAT_B_PCAL_OFF    10
`define MCAT_B_RES8        9
`define MCAT_B_START       0
`define MCAT_B_BUSY        0
`define MCAT_B_CAL         1
`define MCAT_B_DONE        2
// ************************************************************
// encodings, limits and reset values
// ************************************************************
`define MCAT_SRC_PLL       2'h3
`define MCAT_ODIV_MAX      4'hE
`define MCAT_CTRL_RST      16'h0000
`define MCAT_DIV_RST       8'h00
`define MCAT_RES_ZERO      10'h000
`define MCAT_RES_FULL      10'h3FF
`define MCAT_HPER_RST      12'h004
// ************************************************************
// converter cycle budgets in basic clock periods, write phase in system clocks
// ************************************************************
`define MCAT_CONV10_BC     7'h34
`define MCAT_CONV8_BC      7'h2C
`define MCAT_PCAL_BC       7'h0C
`define MCAT_WRITE_SYS     7'h06
`define MCAT_CAL_MIN_BC    14'h01E4
`define MCAT_CAL_MAX_BC    14'h2DB0
`endif

// ---- rtl/mcat_tick_div.v ----
// restartable divider that turns input ticks into one tick every div_i ticks
`timescale 1ns/1ps
`default_nettype none
module mcat_tick_div #(
  parameter W = 9
) (
  input  wire         clk_i,
  input  wire         arst_n_i,
  input  wire         restart_i,
  input  wire         tick_i,
  input  wire [W-1:0] div_i,
  output reg          tick_o
);
  reg [W-1:0] cnt_q;

  // ************************************************************
  // count input ticks, emit one pulse on the last of each group
  // ************************************************************
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q  <= {W{1'b0}};
      tick_o <= 1'b0;
    end else if (restart_i) begin
      cnt_q  <= {W{1'b0}};
      tick_o <= 1'b0;
    end else if (tick_i) begin
      if (cnt_q + {{(W-1){1'b0}}, 1'b1} >= div_i) begin
        cnt_q  <= {W{1'b0}};
        tick_o <= 1'b1;
      end else begin
        cnt_q  <= cnt_q + {{(W-1){1'b0}}, 1'b1};
        tick_o <= 1'b0;
      end
    end else begin
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/mcat_top.v ----
// master clock generation, cpu and system clocks, converter timing
// Notes on behaviour
// - bypass divides oscillator by product of dividers
// - input divider max 3, output max 14
// - both dividers zero: master follows oscillator
// - source 11 runs pll with multiplier
// - pll frequency slews gradually, no step
// - cpu clock is master or half, one bit
// - system clock equals cpu clock frequency
// - prescale code 00..11 gives /4 /2 /16 /8
// - sample code gives 8,16,32,64 basic periods
// - compatibility codes or improved divider selectable
// - conversion: sample, determination, six system clocks
// - post-calibration off saves twelve basic periods
// - under-range reads zero, over-range reads 3FF
// - conversions during calibration extend calibration
// - ten-bit budget 52 or 40 basic periods
// - eight-bit budget 44 or 32 basic periods
// - reset calibration 484 to 11696 basic periods
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "mcat_defs.vh"
module mcat_top #(
  parameter        PW     = 12,
  parameter [13:0] CAL_BC = `MCAT_CAL_MIN_BC
) (
  input  wire                  clk_i,
  input  wire                  arst_n_i,
  input  wire                  osc_i,
  input  wire [`MCAT_AW-1:0]   addr_i,
  input  wire [`MCAT_DW-1:0]   wdata_i,
  input  wire                  wr_i,
  input  wire                  rd_i,
  input  wire                  ain_under_i,
  input  wire                  ain_over_i,
  input  wire [9:0]            ain_code_i,
  output reg  [`MCAT_DW-1:0]   rdata_o,
  output reg                   mclk_o,
  output reg                   cpu_clk_o,
  output reg                   sys_clk_o,
  output reg                   adc_sample_o,
  output reg                   adc_busy_o,
  output reg                   cal_busy_o
);
  // ************************************************************
  // helper functions
  // ************************************************************
  // compatibility prescale code to divisor
  function [8:0] presc_div;
    input [1:0] code;
    begin
      case (code)
        2'h0:    presc_div = 9'h004;
        2'h1:    presc_div = 9'h002;
        2'h2:    presc_div = 9'h010;
        default: presc_div = 9'h008;
      endcase
    end
  endfunction

  // sample code to basic periods
  function [6:0] samp_len;
    input [1:0] code;
    begin
      samp_len = 7'h08 << code;
    end
  endfunction

  // determination budget in basic periods
  function [6:0] conv_len;
    input res8;
    input pcal_off;
    reg [6:0] base;
    begin
      base = res8 ? `MCAT_CONV8_BC : `MCAT_CONV10_BC;
      conv_len = pcal_off ? base - `MCAT_PCAL_BC : base;
    end
  endfunction

  // ************************************************************
  // oscillator pin synchroniser and edge detection
  // ************************************************************
  reg osc_m_q;
  reg osc_s_q;
  reg osc_p_q;
  wire osc_rise = osc_s_q & ~osc_p_q;
  wire osc_edge = osc_s_q ^ osc_p_q;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      osc_m_q <= 1'b0;
      osc_s_q <= 1'b0;
      osc_p_q <= 1'b0;
    end else begin
      osc_m_q <= osc_i;
      osc_s_q <= osc_m_q;
      osc_p_q <= osc_s_q;
    end
  end

  // ************************************************************
  // analog front-end pin synchronisers
  // ************************************************************
  reg [11:0] ain_m_q;
  reg [11:0] ain_s_q;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ain_m_q <= 12'h000;
      ain_s_q <= 12'h000;
    end else begin
      ain_m_q <= {ain_over_i, ain_under_i, ain_code_i};
      ain_s_q <= ain_m_q;
    end
  end

  // ************************************************************
  // register file
  // ************************************************************
  reg [12:0] clk_ctrl_q;
  reg        halve_q;
  reg [15:0] adc_ctrl_q;
  reg [7:0]  adc_div_q;
  reg        done_q;
  reg [9:0]  res_q;
  reg [PW-1:0] osc_per_q;
  reg        busy_q;
  reg        cal_q;
  wire       conv_done;
  wire       wr_clk  = wr_i & (addr_i == `MCAT_REG_CLK_CTRL);
  wire       wr_adc  = wr_i & (addr_i == `MCAT_REG_ADC_CTRL);
  wire       wr_stat = wr_i & (addr_i == `MCAT_REG_ADC_STAT);
  wire       start   = wr_adc & wdata_i[`MCAT_B_START] & ~busy_q;
  wire [3:0] odiv_w  = (wdata_i[`MCAT_F_ODIV] > `MCAT_ODIV_MAX) ?
                       `MCAT_ODIV_MAX : wdata_i[`MCAT_F_ODIV];

  // software writes; done flag set wins over clear
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clk_ctrl_q <= 13'h0000;
      halve_q    <= 1'b0;
      adc_ctrl_q <= `MCAT_CTRL_RST;
      adc_div_q  <= `MCAT_DIV_RST;
      done_q     <= 1'b0;
    end else begin
      if (wr_clk)
        clk_ctrl_q <= {wdata_i[`MCAT_F_MUL], odiv_w, wdata_i[`MCAT_F_IDIV],
                       wdata_i[`MCAT_F_SRC]};
      if (wr_i && addr_i == `MCAT_REG_SYS_CFG)
        halve_q <= wdata_i[0];
      if (wr_adc && !busy_q)
        adc_ctrl_q <= {wdata_i[15:1], 1'b0};
      if (wr_i && addr_i == `MCAT_REG_ADC_DIV)
        adc_div_q <= wdata_i[7:0];
      if (conv_done)
        done_q <= 1'b1;
      else if (wr_stat && wdata_i[`MCAT_B_DONE])
        done_q <= 1'b0;
    end
  end

  // read data one cycle after the read strobe
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      case (addr_i)
        `MCAT_REG_CLK_CTRL: rdata_o <= {3'h0, clk_ctrl_q};
        `MCAT_REG_SYS_CFG:  rdata_o <= {15'h0000, halve_q};
        `MCAT_REG_ADC_CTRL: rdata_o <= {adc_ctrl_q[15:1], busy_q};
        `MCAT_REG_ADC_DIV:  rdata_o <= {8'h00, adc_div_q};
        `MCAT_REG_ADC_STAT: rdata_o <= {13'h0000, done_q, cal_q, busy_q};
        `MCAT_REG_ADC_RES:  rdata_o <= {6'h00, res_q};
        `MCAT_REG_CLK_STAT: rdata_o <= {{(16-PW){1'b0}}, osc_per_q};
        default:            rdata_o <= 16'h0000;
      endcase
    end else begin
      rdata_o <= 16'h0000;
    end
  end

  // ************************************************************
  // active clock settings, taken at a master falling edge or while master is low
  // ************************************************************
  reg [12:0] act_q;
  reg        mclk_fall;
  wire       pll_mode = (act_q[`MCAT_F_SRC] == `MCAT_SRC_PLL);
  wire [2:0] idiv_p1  = {1'b0, act_q[`MCAT_F_IDIV]} + 3'h1;
  wire [4:0] odiv_p1  = {1'b0, act_q[`MCAT_F_ODIV]} + 5'h01;
  wire [5:0] mul_p1   = {1'b0, act_q[`MCAT_F_MUL]} + 6'h01;
  wire [7:0] ndiv     = idiv_p1 * odiv_p1;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      act_q <= 13'h0000;
    else if (mclk_fall || !mclk_o)
      act_q <= clk_ctrl_q;
  end

  // ************************************************************
  // oscillator period measurement, used by the pll loop
  // ************************************************************
  reg [PW-1:0] per_cnt_q;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      per_cnt_q <= {PW{1'b0}};
      osc_per_q <= {PW{1'b0}};
    end else if (osc_rise) begin
      per_cnt_q <= {{(PW-1){1'b0}}, 1'b1};
      osc_per_q <= per_cnt_q;
    end else if (per_cnt_q != {PW{1'b1}}) begin
      per_cnt_q <= per_cnt_q + {{(PW-1){1'b0}}, 1'b1};
    end
  end

  // ************************************************************
  // bypass path: toggle every ndiv oscillator half periods
  // ************************************************************
  reg  [7:0] byp_cnt_q;
  wire       byp_hit = osc_edge && (byp_cnt_q + 8'h01 >= ndiv);

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      byp_cnt_q <= 8'h00;
    else if (pll_mode || byp_hit)
      byp_cnt_q <= 8'h00;
    else if (osc_edge)
      byp_cnt_q <= byp_cnt_q + 8'h01;
  end

  // ************************************************************
  // pll path: half period slews one step per master cycle
  // ************************************************************
  reg  [11:0] hper_q;
  reg  [11:0] hcnt_q;
  wire [19:0] pll_lhs = {7'h00, hper_q, 1'b0} * {14'h0000, mul_p1};
  wire [19:0] pll_rhs = {{(20-PW){1'b0}}, osc_per_q} * {12'h000, ndiv};
  wire        pll_hit = (hcnt_q + 12'h001 >= hper_q);

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hper_q <= `MCAT_HPER_RST;
      hcnt_q <= 12'h000;
    end else if (!pll_mode) begin
      hcnt_q <= 12'h000;
    end else if (pll_hit) begin
      hcnt_q <= 12'h000;
      if (!mclk_o && pll_lhs > pll_rhs && hper_q > 12'h001)
        hper_q <= hper_q - 12'h001;
      else if (!mclk_o && pll_lhs < pll_rhs && hper_q != 12'hFFF)
        hper_q <= hper_q + 12'h001;
    end else begin
      hcnt_q <= hcnt_q + 12'h001;
    end
  end

  // ************************************************************
  // master clock output
  // ************************************************************
  reg mclk_d;

  always @* begin
    mclk_d = mclk_o;
    if (pll_mode) begin
      if (pll_hit)
        mclk_d = ~mclk_o;
    end else if (ndiv == 8'h01) begin
      mclk_d = osc_s_q;
    end else if (byp_hit) begin
      mclk_d = ~mclk_o;
    end
  end

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mclk_o    <= 1'b0;
      mclk_fall <= 1'b0;
    end else begin
      mclk_o    <= mclk_d;
      mclk_fall <= mclk_o & ~mclk_d;
    end
  end

  // ************************************************************
  // cpu and system clocks; halving changes only while both low
  // ************************************************************
  reg  halve_act_q;
  reg  cpu_d;
  wire mrise = mclk_d & ~mclk_o;
  wire sys_tick = cpu_d & ~cpu_clk_o;

  always @* begin
    if (halve_act_q)
      cpu_d = mrise ? ~cpu_clk_o : cpu_clk_o;
    else
      cpu_d = mclk_d;
  end

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      halve_act_q <= 1'b0;
      cpu_clk_o   <= 1'b0;
      sys_clk_o   <= 1'b0;
    end else begin
      if (!mclk_d && !cpu_d)
        halve_act_q <= halve_q;
      cpu_clk_o <= cpu_d;
      sys_clk_o <= cpu_d;
    end
  end

  // ************************************************************
  // converter basic clock
  // ************************************************************
  wire       bc_tick;
  wire [8:0] bc_div = adc_ctrl_q[`MCAT_B_IMPROVED] ?
                      {1'b0, adc_div_q} + 9'h001 :
                      presc_div(adc_ctrl_q[`MCAT_F_PRESC]);

  mcat_tick_div #(
    .W (9)
  ) u_bc_div (
    .clk_i     (clk_i),
    .arst_n_i  (arst_n_i),
    .restart_i (start),
    .tick_i    (sys_tick),
    .div_i     (bc_div),
    .tick_o    (bc_tick)
  );

  // ************************************************************
  // conversion sequencer
  // ************************************************************
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_SAMP = 2'h1;
  localparam [1:0] S_CONV = 2'h2;
  localparam [1:0] S_WRT  = 2'h3;
  reg [1:0] st_q;
  reg [6:0] cnt_q;
  assign conv_done = (st_q == S_WRT) && sys_tick && (cnt_q + 7'h01 >= `MCAT_WRITE_SYS);

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q  <= S_IDLE;
      cnt_q <= 7'h00;
      res_q <= `MCAT_RES_ZERO;
    end else begin
      case (st_q)
        S_IDLE: begin
          cnt_q <= 7'h00;
          if (start)
            st_q <= S_SAMP;
        end
        S_SAMP: begin
          if (bc_tick) begin
            if (cnt_q + 7'h01 >= samp_len(adc_ctrl_q[`MCAT_F_STIME])) begin
              cnt_q <= 7'h00;
              st_q  <= S_CONV;
            end else begin
              cnt_q <= cnt_q + 7'h01;
            end
          end
        end
        S_CONV: begin
          if (bc_tick) begin
            if (cnt_q + 7'h01 >= conv_len(adc_ctrl_q[`MCAT_B_RES8],
                                          adc_ctrl_q[`MCAT_B_PCAL_OFF])) begin
              cnt_q <= 7'h00;
              st_q  <= S_WRT;
            end else begin
              cnt_q <= cnt_q + 7'h01;
            end
          end
        end
        S_WRT: begin
          if (conv_done) begin
            st_q <= S_IDLE;
            if (ain_s_q[10])
              res_q <= `MCAT_RES_ZERO;
            else if (ain_s_q[11])
              res_q <= `MCAT_RES_FULL;
            else
              res_q <= ain_s_q[9:0];
          end else if (sys_tick) begin
            cnt_q <= cnt_q + 7'h01;
          end
        end
        default: begin
          st_q  <= S_IDLE;
          cnt_q <= 7'h00;
        end
      endcase
    end
  end

  // ************************************************************
  // reset calibration; pauses while a conversion runs
  // ************************************************************
  reg [13:0] cal_cnt_q;
  wire [13:0] cal_len = (CAL_BC > `MCAT_CAL_MAX_BC) ? `MCAT_CAL_MAX_BC : CAL_BC;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cal_cnt_q <= 14'h0000;
      cal_q     <= 1'b1;
    end else if (cal_q && bc_tick && st_q == S_IDLE) begin
      if (cal_cnt_q + 14'h0001 >= cal_len)
        cal_q <= 1'b0;
      cal_cnt_q <= cal_cnt_q + 14'h0001;
    end
  end

  // ************************************************************
  // status outputs
  // ************************************************************
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_q       <= 1'b0;
      adc_busy_o   <= 1'b0;
      adc_sample_o <= 1'b0;
      cal_busy_o   <= 1'b0;
    end else begin
      busy_q       <= start | (busy_q & ~conv_done);
      adc_busy_o   <= start | (busy_q & ~conv_done);
      adc_sample_o <= (st_q == S_SAMP);
      cal_busy_o   <= cal_q;
    end
  end
endmodule
`default_nettype wire

// ---- verif/mcat_top_checker.sv ----
// assertions on the ports of the master clock and converter timing block
`timescale 1ns/1ps
`default_nettype none
`include "mcat_defs.vh"
module mcat_top_checker #(
  parameter [13:0] CAL_BC = `MCAT_CAL_MIN_BC
) (
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  input wire logic [2:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        mclk_o,
  input wire logic        cpu_clk_o,
  input wire logic        sys_clk_o,
  input wire logic        adc_busy_o,
  input wire logic        cal_busy_o
);
  // ********
  // helper state
  // ********
  logic [15:0] ctrl_q, cv_q, cal_q;
  logic [7:0]  ph_q, last_q;
  logic [1:0]  npll_q;
  logic        pll_q, mclk_q, sys_q, seen_q;
  wire         mchg  = mclk_o != mclk_q;
  wire         srise = sys_clk_o && !sys_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  // expected system clock rises for one compatibility mode conversion
  function automatic int budget(input logic [15:0] c);
    int dv;
    case (c[`MCAT_F_PRESC])
      2'h0: dv = 4;
      2'h1: dv = 2;
      2'h2: dv = 16;
      default: dv = 8;
    endcase
    return ((8 << c[`MCAT_F_STIME]) + (c[`MCAT_B_RES8] ? 44 : 52)
            - (c[`MCAT_B_PCAL_OFF] ? 12 : 0)) * dv + 6;
  endfunction

  // settings shadow, phase lengths and rise counters
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_q <= 16'h0000;
      cv_q   <= 16'h0000;
      cal_q  <= 16'h0000;
      ph_q   <= 8'h00;
      last_q <= 8'h00;
      npll_q <= 2'h0;
      pll_q  <= 1'b0;
      mclk_q <= 1'b0;
      sys_q  <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      mclk_q <= mclk_o;
      sys_q  <= sys_clk_o;
      seen_q <= seen_q | cal_busy_o;
      if (wr_i && addr_i == `MCAT_REG_ADC_CTRL && !adc_busy_o) begin
        ctrl_q <= wdata_i;
      end
      if (wr_i && addr_i == `MCAT_REG_CLK_CTRL) begin
        pll_q <= wdata_i[`MCAT_F_SRC] == `MCAT_SRC_PLL;
      end
      cv_q  <= adc_busy_o ? cv_q + {15'h0000, srise} : 16'h0000;
      cal_q <= cal_busy_o ? cal_q + {15'h0000, srise} : cal_q;
      if (mchg) begin
        last_q <= ph_q;
        ph_q   <= 8'h01;
        npll_q <= !pll_q ? 2'h0 : (npll_q == 2'h3 ? npll_q : npll_q + 2'h1);
      end else if (ph_q != 8'hFF) begin
        ph_q <= ph_q + 8'h01;
      end
    end
  end

  // ********
  // properties
  // ********
  property p_sys_cpu;
    sys_clk_o == cpu_clk_o;
  endproperty
  a_sys_cpu: assert property (p_sys_cpu)
    else $error("system clock differs from cpu clock");
  property p_cpu_rise;
    $rose(cpu_clk_o) |-> $rose(mclk_o);
  endproperty
  a_cpu_rise: assert property (p_cpu_rise)
    else $error("cpu clock rose without a master rise");
  property p_slew;
    pll_q && npll_q == 2'h3 && mchg |-> ph_q <= last_q + 9'h001 && last_q <= ph_q + 9'h001;
  endproperty
  a_slew: assert property (p_slew)
    else $error("master phase length jumped by more than one");
  property p_start;
    wr_i && addr_i == `MCAT_REG_ADC_CTRL && wdata_i[`MCAT_B_START] && !adc_busy_o
      |=> adc_busy_o;
  endproperty
  a_start: assert property (p_start)
    else $error("conversion start not taken");
  property p_len;
    $fell(adc_busy_o) && !ctrl_q[`MCAT_B_IMPROVED]
      |-> cv_q + 1 >= budget(ctrl_q) && cv_q <= budget(ctrl_q) + 1;
  endproperty
  a_len: assert property (p_len)
    else $error("conversion length off budget");
  property p_cal_hold;
    cal_busy_o && adc_busy_o |=> cal_busy_o;
  endproperty
  a_cal_hold: assert property (p_cal_hold)
    else $error("calibration ended during a conversion");
  property p_cal_once;
    seen_q && !cal_busy_o |=> !cal_busy_o;
  endproperty
  a_cal_once: assert property (p_cal_once)
    else $error("calibration restarted without reset");
  property p_cal_len;
    $fell(cal_busy_o) |-> cal_q >= CAL_BC;
  endproperty
  a_cal_len: assert property (p_cal_len)
    else $error("calibration too short");
  c_conv: cover property ($fell(adc_busy_o));
  c_slew: cover property (pll_q && npll_q == 2'h3 && mchg && ph_q != last_q);
  c_halve: cover property ($rose(mclk_o) && !$rose(cpu_clk_o));
endmodule
bind mcat_top mcat_top_checker #(.CAL_BC(CAL_BC)) i_mcat_top_checker (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .mclk_o(mclk_o), .cpu_clk_o(cpu_clk_o), .sys_clk_o(sys_clk_o),
  .adc_busy_o(adc_busy_o), .cal_busy_o(cal_busy_o)
);
`default_nettype wire

// ---- verif/mcat_top_tb.sv ----
// self-checking testbench for the master clock and converter timing block
`timescale 1ns/1ps
`default_nettype none
`include "mcat_defs.vh"
module mcat_top_tb;
  // ********
  // signals
  // ********
  localparam int P  = 8; // oscillator period in clk cycles, high for 3
  localparam int CB = 8; // shortened calibration in basic ticks
  logic        clk_i, arst_n_i, osc_i, wr_i, rd_i, ain_under_i, ain_over_i, cal_on;
  logic [2:0]  addr_i;
  logic [15:0] wdata_i, rdata_o;
  logic [9:0]  ain_code_i;
  logic        mclk_o, cpu_clk_o, sys_clk_o, adc_sample_o, adc_busy_o, cal_busy_o;
  int          err_count, check_count, cyc, oc;
  int          dv[4] = '{4, 2, 16, 8};

  mcat_top #(.CAL_BC(14'h0008)) i_mcat_top (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .osc_i(osc_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .ain_under_i(ain_under_i),
    .ain_over_i(ain_over_i), .ain_code_i(ain_code_i), .rdata_o(rdata_o),
    .mclk_o(mclk_o), .cpu_clk_o(cpu_clk_o), .sys_clk_o(sys_clk_o),
    .adc_sample_o(adc_sample_o), .adc_busy_o(adc_busy_o), .cal_busy_o(cal_busy_o)
  );

  // clock, oscillator with uneven duty, hang guard
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    oc    <= (oc + 1) % P;
    osc_i <= oc < 3;
    cyc   <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      summarize();
    end
  end

  // ********
  // shared tasks
  // ********
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rc(input logic [2:0] a, input logic [15:0] e, input string n);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(n, e, rdata_o);
  endtask
  // period and high time of the last full cycle of master or cpu clock
  task automatic per(input logic c, input int w, output int n, output int h);
    int i, t;
    logic v, pv;
    t = 0;
    pv = 1'b1;
    n = 0;
    h = 0;
    for (i = 1; i <= w; i++) begin
      @(posedge clk_i);
      v = c ? cpu_clk_o : mclk_o;
      if (v && !pv) begin
        n = i - t;
        t = i;
      end
      if (!v && pv) h = i - t;
      pv = v;
    end
  endtask
  // one conversion: length in system periods, result and done flag
  task automatic conv(input logic [15:0] c, input logic u, input logic o, input logic [9:0] e);
    int n, k, m, s;
    s = (8 << c[13:12]) * (c[11] ? 3 : dv[c[15:14]]);
    k = ((8 << c[13:12]) + (c[9] ? 44 : 52) - (c[10] ? 12 : 0))
        * (c[11] ? 3 : dv[c[15:14]]) + 6;
    ain_under_i <= u;
    ain_over_i  <= o;
    ain_code_i  <= (u | o) ? 10'h2AA : e;
    wr(`MCAT_REG_ADC_CTRL, c | 16'h0001);
    n = 0;
    m = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (adc_sample_o === 1'b1) m++;
    end while (adc_busy_o !== 1'b0 && n < 20000);
    chk("conversion time", 16'h0001, 16'(n >= (k - 1) * P - 2 && n <= k * P + 4));
    chk("sample time", 16'h0001, 16'(m >= (s - 1) * P - 2 && m <= s * P + 4));
    rc(`MCAT_REG_ADC_RES, {6'h00, e}, "result");
    rc(`MCAT_REG_ADC_STAT, {13'h0000, 1'b1, cal_on, 1'b0}, "done set");
    rc(`MCAT_REG_ADC_CTRL, c & 16'hFFFE, "control readback");
    wr(`MCAT_REG_ADC_STAT, 16'h0004);
    rc(`MCAT_REG_ADC_STAT, {13'h0000, 1'b0, cal_on, 1'b0}, "done clear");
  endtask

  // ********
  // scenarios
  // ********
  task automatic t_cal;
    int n;
    conv(16'h0000, 1'b0, 1'b0, 10'h155);
    chk("calibration held", 16'h0001, {15'h0000, cal_busy_o});
    n = 0;
    while (cal_busy_o === 1'b1 && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    chk("calibration end", 16'h0001, 16'(n >= (CB - 2) * 4 * P && n <= CB * 4 * P + 8));
    cal_on = 1'b0;
    $display("test calibration done");
  endtask
  task automatic t_clk;
    int n, h;
    rc(`MCAT_REG_CLK_CTRL, 16'h0000, "clock control reset");
    rc(`MCAT_REG_SYS_CFG, 16'h0000, "system config reset");
    rc(`MCAT_REG_CLK_STAT, 16'(P), "oscillator period");
    wr(3'h7, 16'hFFFF);
    rc(3'h7, 16'h0000, "unmapped index");
    wr(`MCAT_REG_CLK_CTRL, 16'h00FD);
    rc(`MCAT_REG_CLK_CTRL, 16'h00ED, "output divider clamp");
    per(1'b0, 1500, n, h);
    chk("slowest bypass period", 16'(60 * P), 16'(n));
    wr(`MCAT_REG_CLK_CTRL, 16'h0024);
    per(1'b0, 500, n, h);
    chk("bypass period", 16'(6 * P), 16'(n));
    wr(`MCAT_REG_CLK_CTRL, 16'h0000);
    per(1'b0, 200, n, h);
    chk("direct period", 16'(P), 16'(n));
    chk("direct high time", 16'h0003, 16'(h));
    wr(`MCAT_REG_SYS_CFG, 16'h0001);
    per(1'b1, 200, n, h);
    chk("halved cpu period", 16'(2 * P), 16'(n));
    wr(`MCAT_REG_SYS_CFG, 16'h0000);
    wr(`MCAT_REG_CLK_CTRL, 16'h0103);
    per(1'b0, 1200, n, h);
    chk("pll period", 16'(P / 2), 16'(n));
    wr(`MCAT_REG_CLK_CTRL, 16'h0000);
    per(1'b0, 100, n, h);
    $display("test clocks done");
  endtask
  task automatic t_adc;
    int i;
    for (i = 0; i < 4; i++)
      conv({i[1:0], 14'h0000}, 1'b0, 1'b0, 10'h3C3 ^ i[9:0]);
    for (i = 0; i < 4; i++)
      conv({2'h1, i[1:0], 12'h000}, 1'b0, 1'b0, 10'h0F0);
    conv(16'h4400, 1'b0, 1'b0, 10'h201);
    conv(16'h4200, 1'b0, 1'b0, 10'h102);
    conv(16'h4600, 1'b0, 1'b0, 10'h0AB);
    conv(16'h4000, 1'b1, 1'b0, 10'h000);
    conv(16'h4000, 1'b0, 1'b1, 10'h3FF);
    conv(16'h4000, 1'b1, 1'b1, 10'h000);
    wr(`MCAT_REG_ADC_DIV, 16'h0002);
    rc(`MCAT_REG_ADC_DIV, 16'h0002, "divider readback");
    conv(16'h0800, 1'b0, 1'b0, 10'h2D2);
    $display("test converter done");
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // reset, then the scenarios in order
  initial begin
    clk_i = 1'b0;
    arst_n_i = 1'b0;
    osc_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    ain_under_i = 1'b0;
    ain_over_i = 1'b0;
    addr_i = 3'h0;
    wdata_i = 16'h0000;
    ain_code_i = 10'h000;
    err_count = 0;
    check_count = 0;
    cal_on = 1'b1;
    cyc = 0;
    oc = 0;
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_cal();
    t_clk();
    t_adc();
    summarize();
  end
endmodule
`default_nettype wire
